// ---- src/fcsp_pkg.sv ----
// Purpose: shared constants and types for the flow-controlled serial port
// Assumes: 50 MHz system clock, 8 data bits plus optional parity bit
// Notes:   line rate is set by a divisor parameter of each end
package fcsp_pkg;
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned MAX_BAUD     = 1_000_000;
  localparam int unsigned DEF_BAUD     = 1_000_000;
  localparam int unsigned DEF_DIV      = CLK_HZ / DEF_BAUD;
  localparam int unsigned DATA_BITS    = 8;
  localparam int unsigned FIFO_DEPTH   = 4;
  localparam int unsigned RTS_MARGIN   = 2;
  localparam logic        LINE_IDLE    = 1'b1;
  localparam logic        HS_ASSERTED  = 1'b0;
  localparam logic        HS_RELEASED  = 1'b1;

  typedef enum logic [3:0] {
    FC_IDLE  = 4'b0001,
    FC_START = 4'b0010,
    FC_DATA  = 4'b0100,
    FC_STOP  = 4'b1000
  } fcsp_state_t;

  function automatic logic fcsp_parity(input logic [DATA_BITS-1:0] d, input logic odd);
    fcsp_parity = (^d) ^ odd;
  endfunction : fcsp_parity
endpackage : fcsp_pkg

// ---- src/fcsp_link_if.sv ----
// Purpose: the four wires between device and host
// Assumes: single clock
// Notes:   rts_n and cts_n are active low
`timescale 1ns/1ps
`default_nettype none
interface fcsp_link_if;
  logic dev_tx;
  logic host_tx;
  logic dev_rts_n;
  logic host_rts_n;
  modport device (output dev_tx, input host_tx, output dev_rts_n, input host_rts_n);
  modport host   (output host_tx, input dev_tx, output host_rts_n, input dev_rts_n);
endinterface : fcsp_link_if
`default_nettype wire

// ---- src/fcsp_fifo.sv ----
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: synchronous active-high reset
// Notes:   level output gives room accounting for flow control
`timescale 1ns/1ps
`default_nettype none
module fcsp_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic [WIDTH-1:0]         in_data,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  output logic      [WIDTH-1:0]         out_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic      [$clog2(DEPTH+1)-1:0] level
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic             push;
  logic             pop;

  assign in_ready  = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (level != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_idx];

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] i);
    wrap_inc = (i == AW'(DEPTH - 1)) ? '0 : AW'(i + 1'b1);
  endfunction : wrap_inc

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_idx] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_idx <= '0;
      rd_idx <= '0;
      level  <= '0;
    end else begin
      if (push) wr_idx <= wrap_inc(wr_idx);
      if (pop)  rd_idx <= wrap_inc(rd_idx);
      if (push && !pop) level <= level + 1'b1;
      else if (pop && !push) level <= level - 1'b1;
    end
  end
endmodule : fcsp_fifo
`default_nettype wire

// ---- src/fcsp_device.sv ----
// Purpose: device end of a full-duplex UART with RTS/CTS flow control
// Assumes: inputs synchronous to sys_clk; parity on a ninth bit when enabled
// Notes:   received characters (code download included) pass through a FIFO
// Behaviour
// RQ1 - full duplex async link, flow control, 1 Mbps
// RQ2 - ninth bit parity generated and checked
// RQ3 - rts output, cts input, both active low
// RQ4 - serial line idles high
// RQ5 - low handshake level means asserted
// RQ6 - host tx feeds device rx, reverse too
// RQ7 - host stops sending once rts deasserted
// RQ8 - host downloads program code through this port
// RQ9 - early rts release, tx pauses on cts
`timescale 1ns/1ps
`default_nettype none
module fcsp_device
  import fcsp_pkg::*;
#(
  parameter int unsigned DIV   = fcsp_pkg::DEF_DIV,
  parameter int unsigned DEPTH = fcsp_pkg::FIFO_DEPTH
) (
  input  wire logic                               sys_clk,
  input  wire logic                               rst,
  fcsp_link_if.device                             link,
  input  wire logic                               parity_en,
  input  wire logic                               parity_odd,
  input  wire logic [fcsp_pkg::DATA_BITS-1:0]     tx_data,
  input  wire logic                               tx_valid,
  output logic                                    tx_ready,
  output logic      [fcsp_pkg::DATA_BITS-1:0]     rx_data,
  output logic                                    rx_valid,
  input  wire logic                               rx_ready,
  output logic                                    rx_parity_err,
  output logic                                    rx_frame_err
);
  import fcsp_pkg::*;
  localparam int unsigned CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] DIV_LAST  = CW'(DIV - 1); // RQ1
  localparam logic [CW-1:0] DIV_HALF  = CW'((DIV - 1) / 2);

  // index of the last data or parity bit of a frame
  function automatic logic [3:0] last_bit(input logic pe);
    last_bit = 4'(DATA_BITS - 1) + 4'(pe);
  endfunction : last_bit

  // transmitter
  fcsp_state_t            tx_state;
  logic [CW-1:0]          tx_cnt;
  logic [3:0]             tx_bit;
  logic [DATA_BITS:0]     tx_shift;
  logic                   tx_line;

  // a character is taken only while the host asserts its rts, our cts
  assign tx_ready    = (tx_state == FC_IDLE) && (link.host_rts_n == HS_ASSERTED); // RQ9
  assign link.dev_tx = tx_line; // RQ6

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_state <= FC_IDLE;
      tx_cnt   <= '0;
      tx_bit   <= '0;
      tx_shift <= '0;
      tx_line  <= LINE_IDLE; // RQ4
    end else begin
      case (tx_state)
        FC_IDLE: begin
          tx_line <= LINE_IDLE; // RQ4
          if (tx_valid && tx_ready) begin // RQ5
            tx_shift <= {fcsp_parity(tx_data, parity_odd), tx_data}; // RQ2
            tx_state <= FC_START;
            tx_cnt   <= '0;
            tx_line  <= 1'b0;
          end
        end
        FC_START: begin
          if (tx_cnt == DIV_LAST) begin
            tx_cnt   <= '0;
            tx_bit   <= '0;
            tx_line  <= tx_shift[0];
            tx_shift <= tx_shift >> 1;
            tx_state <= FC_DATA;
          end else tx_cnt <= tx_cnt + 1'b1;
        end
        FC_DATA: begin
          if (tx_cnt == DIV_LAST) begin
            tx_cnt <= '0;
            // after the last data or parity bit the line goes to stop
            if (tx_bit == last_bit(parity_en)) begin
              tx_line  <= 1'b1;
              tx_state <= FC_STOP;
            end else begin
              tx_bit   <= tx_bit + 1'b1;
              tx_line  <= tx_shift[0];
              tx_shift <= tx_shift >> 1;
            end
          end else tx_cnt <= tx_cnt + 1'b1;
        end
        FC_STOP: begin
          if (tx_cnt == DIV_LAST) begin
            tx_cnt   <= '0;
            tx_state <= FC_IDLE;
          end else tx_cnt <= tx_cnt + 1'b1;
        end
        default: tx_state <= FC_IDLE;
      endcase
    end
  end

  // receiver
  fcsp_state_t            rx_state;
  logic [CW-1:0]          rx_cnt;
  logic [3:0]             rx_bit;
  logic [DATA_BITS:0]     rx_shift;
  logic                   rx_push;
  logic                   rx_perr;
  logic                   rx_ferr;
  logic                   rx_q;
  logic                   next_rts_n;
  logic [$clog2(DEPTH+1)-1:0] fifo_level;
  logic [DATA_BITS+1:0]   fifo_out;
  logic                   rts_n;

  // one register stage on the serial input
  always_ff @(posedge sys_clk) begin
    if (rst) rx_q <= LINE_IDLE;
    else     rx_q <= link.host_tx; // RQ6
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_state <= FC_IDLE;
      rx_cnt   <= '0;
      rx_bit   <= '0;
      rx_shift <= '0;
      rx_push  <= 1'b0;
      rx_perr  <= 1'b0;
      rx_ferr  <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      case (rx_state)
        FC_IDLE: begin
          rx_cnt <= '0;
          if (rx_q == 1'b0) rx_state <= FC_START;
        end
        FC_START: begin
          // a start bit gone by mid-bit is a glitch
          if (rx_cnt == DIV_HALF) begin
            rx_cnt   <= '0;
            rx_bit   <= '0;
            rx_state <= (rx_q == 1'b0) ? FC_DATA : FC_IDLE;
          end else rx_cnt <= rx_cnt + 1'b1;
        end
        FC_DATA: begin
          if (rx_cnt == DIV_LAST) begin
            rx_cnt <= '0;
            // shift in from the top so the character lands in the low bits
            if (parity_en) rx_shift <= {rx_q, rx_shift[DATA_BITS:1]};
            else           rx_shift <= {1'b0, rx_q, rx_shift[DATA_BITS-1:1]};
            if (rx_bit == last_bit(parity_en)) rx_state <= FC_STOP;
            else rx_bit <= rx_bit + 1'b1;
          end else rx_cnt <= rx_cnt + 1'b1;
        end
        FC_STOP: begin
          if (rx_cnt == DIV_LAST) begin
            rx_cnt   <= '0;
            rx_push  <= 1'b1; // RQ8
            // a low stop bit is flagged, the character is still kept
            rx_ferr  <= (rx_q != 1'b1);
            rx_perr  <= parity_en &&
                        (fcsp_parity(rx_shift[DATA_BITS-1:0], parity_odd) != rx_shift[DATA_BITS]); // RQ2
            rx_state <= FC_IDLE;
          end else rx_cnt <= rx_cnt + 1'b1;
        end
        default: rx_state <= FC_IDLE;
      endcase
    end
  end

  // characters arriving with the buffer full are dropped; rts makes that rare
  fcsp_fifo #(
    .WIDTH (DATA_BITS + 2),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_data   ({rx_ferr, rx_perr, rx_shift[DATA_BITS-1:0]}),
    .in_valid  (rx_push),
    .in_ready  (),
    .out_data  (fifo_out),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .level     (fifo_level)
  );

  // the fifo head drives the receive outputs
  assign rx_data       = fifo_out[DATA_BITS-1:0];
  assign rx_parity_err = fifo_out[DATA_BITS];
  assign rx_frame_err  = fifo_out[DATA_BITS+1];

  // release rts while room for characters in flight remains
  assign next_rts_n = (32'(fifo_level) + RTS_MARGIN > DEPTH) ? HS_RELEASED : HS_ASSERTED; // RQ9
  always_ff @(posedge sys_clk) begin
    if (rst) rts_n <= HS_RELEASED;
    else     rts_n <= next_rts_n;
  end
  assign link.dev_rts_n = rts_n; // RQ3
endmodule : fcsp_device
`default_nettype wire

// ---- src/fcsp_host.sv ----
// Purpose: host end of the flow-controlled serial link
// Assumes: same divisor and parity settings as the device
// Notes:   sends only while the device asserts its rts; rx_hold releases its own rts to hold off receive
`timescale 1ns/1ps
`default_nettype none
module fcsp_host
  import fcsp_pkg::*;
#(
  parameter int unsigned DIV = fcsp_pkg::DEF_DIV
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  fcsp_link_if.host                           link,
  input  wire logic                           parity_en,
  input  wire logic                           parity_odd,
  input  wire logic [fcsp_pkg::DATA_BITS-1:0] tx_data,
  input  wire logic                           tx_valid,
  output logic                                tx_ready,
  input  wire logic                           rx_hold,
  output logic      [fcsp_pkg::DATA_BITS-1:0] rx_data,
  output logic                                rx_valid
);
  import fcsp_pkg::*;
  localparam int unsigned CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] DIV_LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] DIV_HALF = CW'((DIV - 1) / 2);

  logic [CW-1:0]      tcnt;
  logic [3:0]         tbit;
  logic [DATA_BITS+2:0] tsh;
  logic               busy;
  logic               tline;
  logic [3:0]         nbits;

  assign nbits        = 4'(DATA_BITS + 2) + 4'(parity_en);
  assign tx_ready     = !busy && (link.dev_rts_n == HS_ASSERTED); // RQ7
  assign link.host_tx = tline; // RQ6

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy  <= 1'b0;
      tcnt  <= '0;
      tbit  <= '0;
      tsh   <= '1;
      tline <= LINE_IDLE; // RQ4
    end else if (!busy) begin
      tline <= LINE_IDLE;
      if (tx_valid && tx_ready) begin
        busy  <= 1'b1;
        tcnt  <= '0;
        tbit  <= '0;
        tline <= 1'b0;
        tsh   <= parity_en ? {1'b1, 1'b1, fcsp_parity(tx_data, parity_odd), tx_data} // RQ2
                           : {1'b1, 1'b1, 1'b1, tx_data};
      end
    end else if (tcnt == DIV_LAST) begin
      tcnt <= '0;
      tbit <= tbit + 1'b1;
      if (tbit + 1'b1 == nbits) begin
        busy  <= 1'b0;
        tline <= LINE_IDLE;
      end else begin
        tline <= tsh[0];
        tsh   <= {1'b1, tsh[DATA_BITS+2:1]};
      end
    end else tcnt <= tcnt + 1'b1;
  end

  fcsp_state_t          rst_st;
  logic [CW-1:0]        rcnt;
  logic [3:0]           rbit;
  logic [DATA_BITS-1:0] rsh;
  logic                 rq;

  always_ff @(posedge sys_clk) begin
    if (rst) rq <= LINE_IDLE;
    else     rq <= link.dev_tx;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rst_st   <= FC_IDLE;
      rcnt     <= '0;
      rbit     <= '0;
      rsh      <= '0;
      rx_data  <= '0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      case (rst_st)
        FC_IDLE: begin
          rcnt <= '0;
          if (rq == 1'b0) rst_st <= FC_START;
        end
        FC_START: begin
          if (rcnt == DIV_HALF) begin
            rcnt   <= '0;
            rbit   <= '0;
            rst_st <= (rq == 1'b0) ? FC_DATA : FC_IDLE;
          end else rcnt <= rcnt + 1'b1;
        end
        FC_DATA: begin
          if (rcnt == DIV_LAST) begin
            rcnt <= '0;
            if (rbit < 4'(DATA_BITS)) rsh <= {rq, rsh[DATA_BITS-1:1]};
            if (rbit == 4'(DATA_BITS - 1) + 4'(parity_en)) rst_st <= FC_STOP;
            else rbit <= rbit + 1'b1;
          end else rcnt <= rcnt + 1'b1;
        end
        FC_STOP: begin
          if (rcnt == DIV_LAST) begin
            rcnt     <= '0;
            rx_data  <= rsh;
            rx_valid <= 1'b1;
            rst_st   <= FC_IDLE;
          end else rcnt <= rcnt + 1'b1;
        end
        default: rst_st <= FC_IDLE;
      endcase
    end
  end

  // the host asserts its rts unless its user holds it off
  always_ff @(posedge sys_clk) begin
    if (rst) link.host_rts_n <= HS_RELEASED;
    else     link.host_rts_n <= rx_hold ? HS_RELEASED : HS_ASSERTED; // RQ5
  end
endmodule : fcsp_host
`default_nettype wire

// ---- dv/fcsp_assertions.sv ----
// Purpose: link-level checks for the flow-controlled serial port
// Assumes: frame windows of 11 bit times; a frame without parity idles out the last one
// Notes:   watches the interface wires only
`timescale 1ns/1ps
`default_nettype none
module fcsp_assertions #(
  parameter int unsigned DIV = fcsp_pkg::DEF_DIV
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic dev_tx,
  input wire logic host_tx,
  input wire logic dev_rts_n,
  input wire logic host_rts_n
);
  import fcsp_pkg::*;
  localparam int unsigned FLEN = 11 * DIV;
  int unsigned dfc;
  int unsigned hfc;
  // frame position counters, zero between frames
  always_ff @(posedge sys_clk) begin
    if (rst) dfc <= 0;
    else if (dfc != 0) dfc <= (dfc == FLEN - 1) ? 0 : dfc + 1;
    else if (!dev_tx) dfc <= 1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) hfc <= 0;
    else if (hfc != 0) hfc <= (hfc == FLEN - 1) ? 0 : hfc + 1;
    else if (!host_tx) hfc <= 1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_dev_start;
    dfc == 0 && dev_tx == 1'b0;
  endsequence
  sequence s_host_start;
    hfc == 0 && host_tx == 1'b0;
  endsequence
  a_reset_lines_idle: assert property ($fell(rst) |-> dev_tx && host_tx)
    else $error("line not idle after reset");
  a_reset_rts_off: assert property ($fell(rst) |-> dev_rts_n && host_rts_n)
    else $error("rts asserted in reset");
  a_rts_on_after: assert property ($fell(rst) |=> !dev_rts_n && !host_rts_n)
    else $error("rts not asserted after reset");
  a_dev_cts_gate: assert property (s_dev_start |-> $past(host_rts_n) == HS_ASSERTED)
    else $error("device started while cts released");
  a_host_rts_gate: assert property (s_host_start |-> $past(dev_rts_n) == HS_ASSERTED)
    else $error("host started while rts released");
  a_dev_bit_hold: assert property (dfc % DIV != 0 |-> $stable(dev_tx))
    else $error("device line moved inside a bit");
  a_host_bit_hold: assert property (hfc % DIV != 0 |-> $stable(host_tx))
    else $error("host line moved inside a bit");
  a_dev_stop_high: assert property (dfc >= 10 * DIV |-> dev_tx)
    else $error("device stop bit low");
  a_host_stop_high: assert property (hfc >= 10 * DIV |-> host_tx)
    else $error("host stop bit low");
endmodule : fcsp_assertions
`default_nettype wire

// ---- dv/fcsp_tb_top.sv ----
// Purpose: self-checking bench for device and host ends of the serial link
// Assumes: divisor 4 for speed; parity on across the main link but for one exchange
// Notes:   a second device faces a raw driver that ignores its rts
`timescale 1ns/1ps
`default_nettype none
module fcsp_tb_top;
  import fcsp_pkg::*;
  localparam int unsigned DIV = 4;
  logic       sys_clk    = 1'b0;
  logic       rst        = 1'b1;
  logic       par        = 1'b1;
  logic       odd_d      = 1'b0;
  logic       odd_h      = 1'b0;
  logic       h_hold     = 1'b0;
  logic [7:0] txd[2]     = '{8'h00, 8'h00};
  logic       txv[2]     = '{1'b0, 1'b0};
  logic       txr[2];
  logic [7:0] rxd[2];
  logic       rxv[2];
  logic       rxr[2]     = '{1'b0, 1'b0};
  logic       pe[2];
  logic       fe[2];
  logic [7:0] h_rxd;
  logic       h_rxv;
  logic [7:0] hq[$];
  logic [7:0] pat[4]     = '{8'h00, 8'hFF, 8'hA5, 8'h3C};
  int         err_count  = 0;
  int         n_compared = 0;
  fcsp_link_if link();
  fcsp_link_if link2();
  fcsp_device #(.DIV(DIV)) fcsp_device_i (.sys_clk(sys_clk), .rst(rst), .link(link.device),
    .parity_en(par), .parity_odd(odd_d), .tx_data(txd[0]), .tx_valid(txv[0]),
    .tx_ready(txr[0]), .rx_data(rxd[0]), .rx_valid(rxv[0]), .rx_ready(rxr[0]),
    .rx_parity_err(pe[0]), .rx_frame_err(fe[0]));
  fcsp_host #(.DIV(DIV)) fcsp_host_i (.sys_clk(sys_clk), .rst(rst), .link(link.host),
    .parity_en(par), .parity_odd(odd_h), .tx_data(txd[1]), .tx_valid(txv[1]),
    .tx_ready(txr[1]), .rx_hold(h_hold), .rx_data(h_rxd), .rx_valid(h_rxv));
  fcsp_device #(.DIV(DIV)) fcsp_device_rogue_i (.sys_clk(sys_clk), .rst(rst),
    .link(link2.device), .parity_en(1'b0), .parity_odd(1'b0), .tx_data(8'h00),
    .tx_valid(1'b0), .tx_ready(), .rx_data(rxd[1]), .rx_valid(rxv[1]), .rx_ready(rxr[1]),
    .rx_parity_err(pe[1]), .rx_frame_err(fe[1]));
  fcsp_assertions #(.DIV(DIV)) fcsp_assertions_i (.sys_clk(sys_clk), .rst(rst),
    .dev_tx(link.dev_tx), .host_tx(link.host_tx), .dev_rts_n(link.dev_rts_n),
    .host_rts_n(link.host_rts_n));
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (h_rxv === 1'b1) hq.push_back(h_rxd);
  end
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // w selects the sender: 0 device, 1 host
  task automatic send(input int w, input logic [7:0] b);
    int n;
    n = 0;
    @(posedge sys_clk);
    txd[w] <= b;
    txv[w] <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (txr[w] !== 1'b1 && n < 5000);
    check({9'h000, txr[w]}, 10'h001);
    txv[w] <= 1'b0;
  endtask : send
  // w selects the receiver: 0 main device, 1 rogue-facing device
  task automatic pop(input int w, input logic [9:0] exp);
    int n;
    n = 0;
    @(posedge sys_clk);
    rxr[w] <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rxv[w] !== 1'b1 && n < 2000);
    check({9'h000, rxv[w]}, 10'h001);
    check({fe[w], pe[w], rxd[w]}, exp);
    rxr[w] <= 1'b0;
  endtask : pop
  // raw frame without parity, followed by one idle bit time
  task automatic raw(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge sys_clk);
      link2.host_tx <= (i < 10) ? f[i] : 1'b1;
      repeat (DIV - 1) @(posedge sys_clk);
    end
  endtask : raw
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_count++;
    final_report();
  end
  initial begin
    link2.host_tx = 1'b1;
    link2.host_rts_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    check({6'h00, link.dev_tx, link.host_tx, link.dev_rts_n, link.host_rts_n}, 10'h00F);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check({8'h00, link.dev_rts_n, link.host_rts_n}, 10'h000);
    for (int p = 0; p < 2; p++) begin
      odd_d <= p[0];
      odd_h <= p[0];
      fork
        foreach (pat[i]) send(0, pat[i]);
        foreach (pat[i]) send(1, pat[i]);
        foreach (pat[i]) pop(0, {2'b00, pat[i]});
      join
      repeat (12 * DIV) @(posedge sys_clk);
      check(10'(hq.size()), 10'h004);
      foreach (pat[i]) check({2'b00, hq[i]}, {2'b00, pat[i]});
      hq.delete();
    end
    odd_d <= 1'b0;
    odd_h <= 1'b1;
    fork
      send(1, 8'h5A);
      pop(0, 10'h15A);
    join
    odd_h <= 1'b0;
    fork
      begin
        foreach (pat[i]) send(1, pat[i]);
        send(1, 8'h96);
      end
    join_none
    repeat (250) @(posedge sys_clk);
    check({8'h00, link.dev_rts_n, txr[1]}, 10'h002);
    foreach (pat[i]) pop(0, {2'b00, pat[i]});
    pop(0, 10'h096);
    wait fork;
    h_hold <= 1'b1;
    repeat (3) @(posedge sys_clk);
    fork
      send(0, 8'hC3);
    join_none
    repeat (100) @(posedge sys_clk);
    check({8'h00, link.dev_tx, txr[0]}, 10'h002);
    h_hold <= 1'b0;
    wait fork;
    repeat (12 * DIV) @(posedge sys_clk);
    check(10'(hq.size()), 10'h001);
    check({2'b00, hq[0]}, 10'h0C3);
    par <= 1'b0;
    fork
      send(0, 8'h69);
      send(1, 8'h96);
      pop(0, 10'h096);
    join
    repeat (12 * DIV) @(posedge sys_clk);
    check(10'(hq.size()), 10'h002);
    check({2'b00, hq[1]}, 10'h069);
    foreach (pat[i]) raw(pat[i], 1'b1);
    raw(8'h81, 1'b1);
    check({9'h000, link2.dev_rts_n}, 10'h001);
    foreach (pat[i]) pop(1, {2'b00, pat[i]});
    @(posedge sys_clk);
    check({8'h00, rxv[1], link2.dev_tx}, 10'h001);
    raw(8'h7E, 1'b0);
    pop(1, 10'h27E);
    final_report();
  end
endmodule : fcsp_tb_top
`default_nettype wire
